// >>> irq_gate_pkg.sv
// Package with the register map, field positions and carrier types of the interrupt gate.
package irq_gate_pkg;

  // ----------------------------------------------------------------------------------------
  // Register addresses and pages
  // ----------------------------------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hA8;  // Enable register, all pages.
  localparam logic [7:0] TIMER_CTRL_ADDR = 8'h88;  // Timer control register, all pages.
  localparam logic [7:0] EXT_CFG_ADDR    = 8'hE4;  // External input configuration register.
  localparam logic [7:0] PAGE_SEL_ADDR   = 8'hA7;  // Register page select, all pages.
  localparam logic [7:0] PAGE_NEXT_ADDR  = 8'h85;  // Second byte of the page stack.
  localparam logic [7:0] PAGE_LAST_ADDR  = 8'h86;  // Bottom byte of the page stack.
  localparam logic [7:0] PAGE_ZERO       = 8'h00;
  localparam logic [7:0] PAGE_HIGH       = 8'h0F;

  // ----------------------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
  localparam logic [7:0] EXT_CFG_RST    = 8'h01;
  localparam logic [7:0] PAGE_RST       = 8'h00;

  // ----------------------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------------------
  localparam int GLOBAL_GATE_BIT   = 7;  // Enable register bit 7.
  localparam int EXT0_SENSE_BIT    = 0;  // Timer control bits.
  localparam int EXT0_PENDING_BIT  = 1;
  localparam int EXT1_SENSE_BIT    = 2;
  localparam int EXT1_PENDING_BIT  = 3;
  localparam int TIMER0_RUN_BIT    = 4;
  localparam int TIMER0_OVF_BIT    = 5;
  localparam int TIMER1_RUN_BIT    = 6;
  localparam int TIMER1_OVF_BIT    = 7;
  localparam int EXT0_PIN_LSB      = 0;  // Configuration register fields.
  localparam int EXT0_POLARITY_BIT = 3;
  localparam int EXT1_PIN_LSB      = 4;
  localparam int EXT1_POLARITY_BIT = 7;

  // Source indices, lowest index wins among equal priority.
  localparam int NUM_SRC  = 7;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_UART = 4;
  localparam int SRC_TMR2 = 5;
  localparam int SRC_SPI  = 6;

  // ----------------------------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;    // Register address.
    logic [7:0] wrData;  // Byte write data.
    logic       wr;      // Byte write strobe.
    logic       rd;      // Byte read strobe.
    logic       bitWr;   // Single-bit write strobe.
    logic [2:0] bitSel;  // Bit position for a single-bit write.
    logic       bitVal;  // Value for a single-bit write.
  } reg_req_t;

  typedef struct packed {
    logic       instrEnd;     // Pulse: current instruction completes this cycle.
    logic       nextSingle;   // Level: the following instruction is single-cycle.
    logic       retiDone;     // Pulse: return-from-interrupt completes this cycle.
  } core_stat_t;

endpackage

// >>> irq_gate.sv
// Interrupt gating, priority selection, external inputs and page stack of the microcontroller.

module irq_gate #(
  parameter int         PIN_W       = 8,       // Width of the watched port.
  parameter logic [15:0] VECTOR_BASE = 16'h0003, // Address of the first vector.
  parameter logic [15:0] VECTOR_STEP = 16'h0008  // Spacing between vectors.
) (
  input  wire logic                        core_clk,        // System clock.
  input  wire logic                        sys_rst,         // Synchronous reset, active high.
  input  wire irq_gate_pkg::reg_req_t      regReq,          // Register access from the core.
  output logic [7:0]                       regRdData,       // Read data, one cycle after rd.
  input  wire irq_gate_pkg::core_stat_t    coreStat,        // Instruction progress from the core.
  input  wire logic [PIN_W-1:0]            portPins,        // Port pins, asynchronous.
  input  wire logic                        timer0Ovf,       // Timer 0 overflow pulse.
  input  wire logic                        timer1Ovf,       // Timer 1 overflow pulse.
  input  wire logic                        timer2LowOvf,    // Timer 2 low overflow flag.
  input  wire logic                        timer2HighOvf,   // Timer 2 high overflow flag.
  input  wire logic                        uartPending,     // Serial port 0 pending flag.
  input  wire logic                        spiPending,      // Serial peripheral pending flag.
  input  wire logic [6:0]                  srcPriority,     // Per-source high priority select.
  output logic                             irqRequest,      // Level: an enabled request waits.
  output logic                             vectorTake,      // Pulse: core must long-call now.
  output logic [15:0]                      vectorAddr,      // Vector address of the last take.
  output logic [2:0]                       vectorSrc,       // Source index of the last take.
  output logic [7:0]                       pageSelect,      // Current register page.
  output logic                             timer0Run,       // Timer 0 run bit.
  output logic                             timer1Run        // Timer 1 run bit.
);

  // ----------------------------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------------------------
  function automatic logic [2:0] firstSet(input logic [6:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = irq_gate_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction
  function automatic logic [7:0] putBit(input logic [7:0] cur, input logic [2:0] sel, input logic val);
    logic [7:0] res;
    res      = cur;
    res[sel] = val;
    return res;
  endfunction

  // ----------------------------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------------------------
  logic [7:0] irqEnable_r, timerCtrl_r, extCfg_r, pageNext_r, pageLast_r, pageSel_r;
  logic       hitEnable, hitCtrl, hitCfg, hitPage, hitNext, hitLast;
  logic [7:0] enableNew, ctrlNew, ctrlRead;
  logic       enableWr, ctrlWr;

  assign hitEnable = (regReq.addr == irq_gate_pkg::IRQ_ENABLE_ADDR);
  assign hitCtrl   = (regReq.addr == irq_gate_pkg::TIMER_CTRL_ADDR);
  assign hitCfg    = (regReq.addr == irq_gate_pkg::EXT_CFG_ADDR) && (pageSel_r == irq_gate_pkg::PAGE_HIGH);
  assign hitPage   = (regReq.addr == irq_gate_pkg::PAGE_SEL_ADDR);
  assign hitNext   = (regReq.addr == irq_gate_pkg::PAGE_NEXT_ADDR);
  assign hitLast   = (regReq.addr == irq_gate_pkg::PAGE_LAST_ADDR);
  assign enableWr  = hitEnable && (regReq.wr || regReq.bitWr);
  assign ctrlWr    = hitCtrl && (regReq.wr || regReq.bitWr);
  assign enableNew = regReq.bitWr ? putBit(irqEnable_r, regReq.bitSel, regReq.bitVal) : regReq.wrData;
  assign ctrlNew   = regReq.bitWr ? putBit(timerCtrl_r, regReq.bitSel, regReq.bitVal) : regReq.wrData;

  // ----------------------------------------------------------------------------------------
  // External input synchronisers and filters
  // ----------------------------------------------------------------------------------------
  logic [PIN_W-1:0] pinS1_r, pinS2_r, pinS3_r, pinLvl_r;
  logic [1:0]       extActive, extActivePrev_r, extEdge, extSense;
  logic [2:0]       ext0Pin, ext1Pin;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinS1_r  <= '0;
      pinS2_r  <= '0;
      pinS3_r  <= '0;
      pinLvl_r <= '0;
    end else begin
      pinS1_r <= portPins;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      for (int i = 0; i < PIN_W; i++) begin
        if (pinS2_r[i] == pinS3_r[i]) begin
          pinLvl_r[i] <= pinS3_r[i];
        end
      end
    end
  end

  assign ext0Pin      = extCfg_r[irq_gate_pkg::EXT0_PIN_LSB +: 3];
  assign ext1Pin      = extCfg_r[irq_gate_pkg::EXT1_PIN_LSB +: 3];
  // Polarity one selects active high, zero selects active low.
  assign extActive[0] = pinLvl_r[ext0Pin] ~^ extCfg_r[irq_gate_pkg::EXT0_POLARITY_BIT];
  assign extActive[1] = pinLvl_r[ext1Pin] ~^ extCfg_r[irq_gate_pkg::EXT1_POLARITY_BIT];
  assign extSense     = {timerCtrl_r[irq_gate_pkg::EXT1_SENSE_BIT], timerCtrl_r[irq_gate_pkg::EXT0_SENSE_BIT]};
  assign extEdge      = extActive & ~extActivePrev_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      extActivePrev_r <= '0;
    end else begin
      extActivePrev_r <= extActive;
    end
  end

  // ----------------------------------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------------------------------
  logic [6:0] pendVec, enabledVec, hiSet, loSet;
  logic       inHigh_r, inLow_r, reqNow, reqHigh, reqStale_r, reqStaleHigh_r, clearSeen_r, holdOne_r, takeHigh;
  logic [2:0] reqIdx, reqStaleIdx_r, takeIdx;
  logic [1:0] extPendRead;

  // Level mode reads the live input; edge mode reads the latched flag.
  assign extPendRead[0] = extSense[0] ? timerCtrl_r[irq_gate_pkg::EXT0_PENDING_BIT] : extActive[0];
  assign extPendRead[1] = extSense[1] ? timerCtrl_r[irq_gate_pkg::EXT1_PENDING_BIT] : extActive[1];

  always_comb begin
    pendVec                          = '0;
    pendVec[irq_gate_pkg::SRC_EXT0]  = extPendRead[0];
    pendVec[irq_gate_pkg::SRC_TMR0]  = timerCtrl_r[irq_gate_pkg::TIMER0_OVF_BIT];
    pendVec[irq_gate_pkg::SRC_EXT1]  = extPendRead[1];
    pendVec[irq_gate_pkg::SRC_TMR1]  = timerCtrl_r[irq_gate_pkg::TIMER1_OVF_BIT];
    pendVec[irq_gate_pkg::SRC_UART]  = uartPending;
    pendVec[irq_gate_pkg::SRC_TMR2]  = timer2LowOvf | timer2HighOvf;
    pendVec[irq_gate_pkg::SRC_SPI]   = spiPending;
  end

  // Enable bits six to zero line up with source indices six to zero.
  assign enabledVec = pendVec & irqEnable_r[6:0]
                    & {7{irqEnable_r[irq_gate_pkg::GLOBAL_GATE_BIT]}};
  assign hiSet      = enabledVec & srcPriority;
  assign loSet      = enabledVec & ~srcPriority;

  // A high request pre-empts a low routine; nothing pre-empts a high routine.
  always_comb begin
    reqNow  = 1'b0;
    reqHigh = 1'b0;
    reqIdx  = 3'h0;
    if ((hiSet != '0) && !inHigh_r) begin
      reqNow  = 1'b1;
      reqHigh = 1'b1;
      reqIdx  = firstSet(hiSet);
    end else if ((loSet != '0) && !inHigh_r && !inLow_r) begin
      reqNow = 1'b1;
      reqIdx = firstSet(loSet);
    end
  end

  assign irqRequest = reqNow;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reqStale_r     <= 1'b0;
      reqStaleHigh_r <= 1'b0;
      reqStaleIdx_r  <= 3'h0;
    end else begin
      reqStale_r     <= reqNow;
      reqStaleHigh_r <= reqHigh;
      reqStaleIdx_r  <= reqIdx;
    end
  end

  // An enable cleared during the current instruction still lets a posted request through
  // only when a single-cycle instruction follows.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clearSeen_r <= 1'b0;
    end else if (enableWr && ((irqEnable_r & ~enableNew) != '0)) begin
      clearSeen_r <= 1'b1;
    end else if (coreStat.instrEnd) begin
      clearSeen_r <= 1'b0;
    end
  end

  // After a return one more instruction must complete before any new take.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      holdOne_r <= 1'b0;
    end else if (coreStat.retiDone) begin
      holdOne_r <= 1'b1;
    end else if (coreStat.instrEnd) begin
      holdOne_r <= 1'b0;
    end
  end

  assign vectorTake = coreStat.instrEnd && !coreStat.retiDone && !holdOne_r
                    && (clearSeen_r ? (reqStale_r && coreStat.nextSingle) : reqNow);

  // ----------------------------------------------------------------------------------------
  // Take record and service levels
  // ----------------------------------------------------------------------------------------
  assign takeIdx  = clearSeen_r ? reqStaleIdx_r : reqIdx;
  assign takeHigh = clearSeen_r ? reqStaleHigh_r : reqHigh;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vectorAddr <= VECTOR_BASE;
      vectorSrc  <= 3'h0;
    end else if (vectorTake) begin
      vectorAddr <= VECTOR_BASE + 16'(VECTOR_STEP * takeIdx);
      vectorSrc  <= takeIdx;
    end
  end

  // Return closes the highest open level, so execution resumes where it was.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inHigh_r <= 1'b0;
      inLow_r  <= 1'b0;
    end else if (vectorTake) begin
      if (takeHigh) begin
        inHigh_r <= 1'b1;
      end else begin
        inLow_r <= 1'b1;
      end
    end else if (coreStat.retiDone) begin
      if (inHigh_r) begin
        inHigh_r <= 1'b0;
      end else begin
        inLow_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqEnable_r <= irq_gate_pkg::IRQ_ENABLE_RST;
    end else if (enableWr) begin
      irqEnable_r <= enableNew;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      extCfg_r <= irq_gate_pkg::EXT_CFG_RST;
    end else if (hitCfg && regReq.wr) begin
      extCfg_r <= regReq.wrData;
    end
  end

  // Pending flags: a write or auto-clear is applied first, then hardware events set,
  // so an event in the clearing cycle is kept.
  always_ff @(posedge core_clk) begin
    logic [7:0] nxt;
    nxt = timerCtrl_r;
    if (ctrlWr) begin
      nxt = ctrlNew;
    end
    if (vectorTake) begin
      case (takeIdx)
        3'(irq_gate_pkg::SRC_EXT0): begin
          if (extSense[0]) begin
            nxt[irq_gate_pkg::EXT0_PENDING_BIT] = 1'b0;
          end
        end
        3'(irq_gate_pkg::SRC_EXT1): begin
          if (extSense[1]) begin
            nxt[irq_gate_pkg::EXT1_PENDING_BIT] = 1'b0;
          end
        end
        3'(irq_gate_pkg::SRC_TMR0): nxt[irq_gate_pkg::TIMER0_OVF_BIT] = 1'b0;
        3'(irq_gate_pkg::SRC_TMR1): nxt[irq_gate_pkg::TIMER1_OVF_BIT] = 1'b0;
        default: ;
      endcase
    end
    if (extSense[0] && extEdge[0]) begin
      nxt[irq_gate_pkg::EXT0_PENDING_BIT] = 1'b1;
    end
    if (extSense[1] && extEdge[1]) begin
      nxt[irq_gate_pkg::EXT1_PENDING_BIT] = 1'b1;
    end
    if (timer0Ovf) begin
      nxt[irq_gate_pkg::TIMER0_OVF_BIT] = 1'b1;
    end
    if (timer1Ovf) begin
      nxt[irq_gate_pkg::TIMER1_OVF_BIT] = 1'b1;
    end
    if (sys_rst) begin
      timerCtrl_r <= irq_gate_pkg::TIMER_CTRL_RST;
    end else begin
      timerCtrl_r <= nxt;
    end
  end

  assign timer0Run = timerCtrl_r[irq_gate_pkg::TIMER0_RUN_BIT];
  assign timer1Run = timerCtrl_r[irq_gate_pkg::TIMER1_RUN_BIT];

  // ----------------------------------------------------------------------------------------
  // Page stack
  // ----------------------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pageSel_r  <= irq_gate_pkg::PAGE_RST;
      pageNext_r <= irq_gate_pkg::PAGE_RST;
      pageLast_r <= irq_gate_pkg::PAGE_RST;
    end else if (vectorTake) begin
      pageSel_r  <= irq_gate_pkg::PAGE_ZERO;
      pageNext_r <= pageSel_r;
      pageLast_r <= pageNext_r;
    end else if (coreStat.retiDone) begin
      pageSel_r  <= pageNext_r;
      pageNext_r <= pageLast_r;
      pageLast_r <= irq_gate_pkg::PAGE_ZERO;
    end else if (regReq.wr) begin
      if (hitPage) begin
        pageSel_r <= regReq.wrData;
      end
      if (hitNext) begin
        pageNext_r <= regReq.wrData;
      end
      if (hitLast) begin
        pageLast_r <= regReq.wrData;
      end
    end
  end

  assign pageSelect = pageSel_r;

  // ----------------------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------------------
  always_comb begin
    ctrlRead                                  = timerCtrl_r;
    ctrlRead[irq_gate_pkg::EXT0_PENDING_BIT]  = extPendRead[0];
    ctrlRead[irq_gate_pkg::EXT1_PENDING_BIT]  = extPendRead[1];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regReq.rd) begin
      regRdData <= hitEnable ? irqEnable_r : hitCtrl ? ctrlRead : hitCfg ? extCfg_r :
                   hitPage ? pageSel_r : hitNext ? pageNext_r : hitLast ? pageLast_r : 8'h00;
    end
  end

endmodule // irq_gate

// >>> irq_gate_chk.sv
// Port checker of the interrupt gate, bound to its top module.
module irq_gate_chk #(
  parameter logic [15:0] VECTOR_BASE = 16'h0003,  // First vector address.
  parameter logic [15:0] VECTOR_STEP = 16'h0008   // Vector spacing.
) (
  input wire logic                     core_clk,    // System clock.
  input wire logic                     sys_rst,     // Synchronous reset.
  input wire irq_gate_pkg::reg_req_t   regReq,      // Register access.
  input wire logic [7:0]               regRdData,   // Read data.
  input wire irq_gate_pkg::core_stat_t coreStat,    // Instruction progress.
  input wire logic                     irqRequest,  // Request level.
  input wire logic                     vectorTake,  // Take pulse.
  input wire logic [15:0]              vectorAddr,  // Vector address.
  input wire logic [2:0]               vectorSrc,   // Vector source.
  input wire logic [7:0]               pageSelect   // Current page.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] enShadow_r;
  logic       holdOne_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) enShadow_r <= 8'h00;
    else if (regReq.wr && regReq.addr == irq_gate_pkg::IRQ_ENABLE_ADDR) enShadow_r <= regReq.wrData;
    else if (regReq.bitWr && regReq.addr == irq_gate_pkg::IRQ_ENABLE_ADDR) enShadow_r[regReq.bitSel] <= regReq.bitVal;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) holdOne_r <= 1'b0;
    else if (coreStat.retiDone) holdOne_r <= 1'b1;
    else if (coreStat.instrEnd) holdOne_r <= 1'b0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    vectorTake;
  endsequence
  sequence s_read_en;
    regReq.rd && !regReq.wr && !regReq.bitWr && regReq.addr == irq_gate_pkg::IRQ_ENABLE_ADDR;
  endsequence
  a_take_at_end: assert property (s_take |-> coreStat.instrEnd && !coreStat.retiDone)
    else $error("Take away from an instruction end.");
  a_gate_closed: assert property (!enShadow_r[7] |-> !irqRequest)
    else $error("Request while the global gate is closed.");
  a_masked_no_take: assert property (!enShadow_r[7] && !$past(enShadow_r[7]) |-> !vectorTake)
    else $error("Take while masked.");
  a_vector_addr: assert property (s_take |=> vectorAddr == VECTOR_BASE + VECTOR_STEP * vectorSrc)
    else $error("Vector address does not match its source.");
  a_page_zero: assert property (s_take |=> pageSelect == 8'h00)
    else $error("Page not zero after a take.");
  a_hold_one: assert property (coreStat.instrEnd && holdOne_r |-> !vectorTake)
    else $error("Take right after a return.");
  a_req_before: assert property (s_take |-> irqRequest || $past(irqRequest))
    else $error("Take without a request.");
  a_enable_read: assert property (s_read_en |=> regRdData == enShadow_r)
    else $error("Enable register read mismatch.");
endmodule // irq_gate_chk

bind irq_gate irq_gate_chk #(.VECTOR_BASE(VECTOR_BASE), .VECTOR_STEP(VECTOR_STEP)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData), .coreStat(coreStat),
  .irqRequest(irqRequest), .vectorTake(vectorTake), .vectorAddr(vectorAddr), .vectorSrc(vectorSrc),
  .pageSelect(pageSelect));

// >>> core_model.sv
// Behavioural processor core that ends instructions and returns from service routines.
module core_model #(
  parameter int PERIOD  = 3,  // Cycles per instruction.
  parameter int ISR_LEN = 4   // Instructions in a service routine.
) (
  input  wire logic                core_clk,    // System clock.
  input  wire logic                sys_rst,     // Synchronous reset.
  input  wire logic                vectorTake,  // Long call request.
  output irq_gate_pkg::core_stat_t coreStat     // Instruction progress.
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt_r;
  int   isrLeft_r;
  logic endNow;
  assign endNow = (cnt_r == PERIOD - 1);
  always_ff @(posedge core_clk) begin
    if (sys_rst) cnt_r <= 0;
    else cnt_r <= endNow ? 0 : cnt_r + 1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) isrLeft_r <= 0;
    else if (vectorTake) isrLeft_r <= ISR_LEN;
    else if (endNow && isrLeft_r != 0) isrLeft_r <= isrLeft_r - 1;
  end
  assign coreStat.instrEnd   = endNow;
  assign coreStat.nextSingle = isrLeft_r[0];
  assign coreStat.retiDone   = endNow && isrLeft_r == 1;
endmodule // core_model

// >>> irq_gating_and_external_irq_tb.sv
// Self-checking testbench of the interrupt gate.
module irq_gating_and_external_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VB = 16'h0003;
  localparam logic [15:0] VS = 16'h0008;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  irq_gate_pkg::reg_req_t regReq = '0;
  irq_gate_pkg::core_stat_t coreStat;
  logic [7:0] regRdData, pageSelect, portPins = 8'hFF;
  logic [15:0] vectorAddr;
  logic [2:0] vectorSrc;
  logic t0 = 1'b0, t1 = 1'b0, irqRequest, vectorTake, takeArm = 1'b0, rdArm = 1'b0;
  logic perP = 1'b0, t0Run, t1Run;
  logic [1:0] expRun = 2'h0;
  logic [6:0] prio = 7'h00;
  logic [31:0] seed = 32'h0000002E;
  logic [23:0] vecQ[$], rdQ[$];
  int failCount = 0, compares = 0;
  always #4 core_clk = ~core_clk;
  irq_gate #(.PIN_W(8), .VECTOR_BASE(VB), .VECTOR_STEP(VS)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .regReq(regReq), .regRdData(regRdData), .coreStat(coreStat), .portPins(portPins), .timer0Ovf(t0),
    .timer1Ovf(t1), .timer2LowOvf(1'b0), .timer2HighOvf(1'b0), .uartPending(perP), .spiPending(perP),
    .srcPriority(prio), .irqRequest(irqRequest), .vectorTake(vectorTake), .vectorAddr(vectorAddr),
    .vectorSrc(vectorSrc), .pageSelect(pageSelect), .timer0Run(t0Run), .timer1Run(t1Run));
  core_model #(.PERIOD(3), .ISR_LEN(4)) core (.core_clk(core_clk), .sys_rst(sys_rst),
    .vectorTake(vectorTake), .coreStat(coreStat));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [23:0] vx(input int s);
    return {VB + VS * 16'(s), 8'h00};
  endfunction
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input bit have);
    compares++;
    if (!have || got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Results are compared off the clock edge, once the design's updates have landed.
  always @(negedge core_clk) begin
    if (takeArm) cmp({vectorAddr, pageSelect}, vecQ.size() != 0 ? vecQ[0] : 24'h0, vecQ.size() != 0);
    if (takeArm && vecQ.size() != 0) void'(vecQ.pop_front());
    if (rdArm) cmp({14'h0, t1Run, t0Run, regRdData}, rdQ.size() != 0 ? rdQ[0] : 24'h0, rdQ.size() != 0);
    if (rdArm && rdQ.size() != 0) void'(rdQ.pop_front());
    takeArm = vectorTake;
    rdArm = regReq.rd;
  end
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wrByte(input logic [7:0] a, input logic [7:0] d);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.wr = 1'b1;
    tick();
    regReq.wr = 1'b0;
  endtask
  task automatic bitWrite(input logic [7:0] a, input logic [2:0] s, input logic v);
    regReq.addr = a;
    regReq.bitSel = s;
    regReq.bitVal = v;
    regReq.bitWr = 1'b1;
    tick();
    regReq.bitWr = 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back({14'h0, expRun, e});
    regReq.addr = a;
    regReq.rd = 1'b1;
    tick();
    regReq.rd = 1'b0;
    tick();
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic waitTakes();
    for (int i = 0; i < 200 && vecQ.size() != 0; i++) tick();
    if (vecQ.size() != 0) begin
      failCount++;
      testDone();
    end
    repeat (20) tick();
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) tick();
    rdChk(8'hA8, 8'h00);
    rdChk(8'h88, 8'h00);
    rdChk(8'hA7, 8'h00);
    rdChk(8'h99, 8'h00);
    seed = xs(seed);
    wrByte(8'hA8, seed[7:0] & 8'h7F);
    rdChk(8'hA8, seed[7:0] & 8'h7F);
    wrByte(8'hA8, 8'h00);
    portPins = 8'hFD;
    repeat (5) tick();
    rdChk(8'h88, 8'h02);
    portPins = 8'hFF;
    repeat (5) tick();
    rdChk(8'h88, 8'h00);
    t0 = 1'b1;
    tick();
    t0 = 1'b0;
    rdChk(8'h88, 8'h20);
    bitWrite(8'hA8, 3'h1, 1'b1);
    repeat (9) tick();
    wrByte(8'hA7, 8'h0F);
    vecQ.push_back(vx(irq_gate_pkg::SRC_TMR0));
    bitWrite(8'hA8, 3'h7, 1'b1);
    waitTakes();
    rdChk(8'h88, 8'h00);
    rdChk(8'hA7, 8'h0F);
    bitWrite(8'h88, 3'h0, 1'b1);
    tick();
    bitWrite(8'hA8, 3'h0, 1'b1);
    vecQ.push_back(vx(irq_gate_pkg::SRC_EXT0));
    portPins = 8'hFD;
    waitTakes();
    rdChk(8'h88, 8'h01);
    portPins = 8'hFF;
    bitWrite(8'hA8, 3'h3, 1'b1);
    vecQ.push_back(vx(irq_gate_pkg::SRC_TMR0));
    vecQ.push_back(vx(irq_gate_pkg::SRC_TMR1));
    {t0, t1} = 2'h3;
    tick();
    {t0, t1} = 2'h0;
    waitTakes();
    rdChk(8'h88, 8'h01);
    prio = 7'h04;
    bitWrite(8'hA8, 3'h2, 1'b1);
    vecQ.push_back(vx(irq_gate_pkg::SRC_EXT1));
    portPins = 8'hFE;
    repeat (8) tick();
    portPins = 8'hFF;
    waitTakes();
    perP = 1'b1;
    repeat (9) tick();
    perP = 1'b0;
    vecQ.push_back(vx(irq_gate_pkg::SRC_TMR1));
    bitWrite(8'h88, 3'h7, 1'b1);
    waitTakes();
    bitWrite(8'h88, 3'h4, 1'b1);
    expRun = 2'h1;
    rdChk(8'h88, 8'h11);
    testDone();
  end
endmodule // irq_gating_and_external_irq_tb
